/* File: fcs_pkg.sv */
`default_nettype none
package fcs_pkg;
  // register byte offsets on the APB side
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [3:0] WIN_RXBUF = 4'h1;
  localparam logic [3:0] WIN_TXBUF = 4'h2;

  // port_control_one fields
  localparam int C1_ENABLE = 0;
  localparam int C1_FS_DIR = 1;
  localparam int C1_IDLE_MODE = 2;
  localparam int C1_MODE_LSB = 4;
  localparam int C1_DIV_LSB = 16;
  localparam int DIV_W = 12;
  localparam logic [31:0] C1_MASK = 32'h0FFF_0037;
  localparam logic [31:0] C1_RESET = 32'h0000_0000;

  // port_control_two fields
  localparam int C2_CLK_DIR = 0;
  localparam int C2_EDGE = 1;
  localparam int C2_WS_LSB = 4;
  localparam int C2_FL_LSB = 8;
  localparam logic [31:0] C2_MASK = 32'h0000_0FF3;
  localparam logic [31:0] C2_RESET = 32'h0000_00F0;

  // frame_sync_mode_field encodings
  localparam logic [1:0] MODE_MC = 2'h0;
  localparam logic [1:0] MODE_I2S = 2'h1;
  localparam logic [1:0] MODE_AC16 = 2'h2;
  localparam logic [1:0] MODE_AC20 = 2'h3;

  // fixed link geometry
  localparam logic [7:0] AC_FRAME_LAST = 8'hFF;
  localparam logic [7:0] AC_SYNC_LAST = 8'h0E;
  localparam logic [4:0] AC_TAG_LAST = 5'h0F;
  localparam logic [4:0] AC20_SLOT_LAST = 5'h13;
  localparam logic [4:0] WORD_LAST_MAX = 5'h0F;

  // synchroniser lanes
  localparam int SY_BCLK = 0;
  localparam int SY_FS = 1;
  localparam int SY_SDI = 2;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} fcs_state_e;
endpackage : fcs_pkg
`default_nettype wire

/* File: fcs_codec_port.sv */
// Behaviour
// - bit clock pin is driven out or taken in, per bit_clock_direction.
// - external bit clock means the internal divider is ignored.
// - data out drives only data bits; idle bits driven low or released.
// - frame_sync_direction clear makes us sync master, set makes us slave.
// - short received words stored left justified, low bits zero.
// - one 16-bit shift register, most significant bit first.
// - one 2-bit index, prefixed 0 for receive and 1 for transmit.
// - clearing port_enable resets counters and stops the port.
// - while enabled the port owns direction and value of its pins.
// - bit clock generator may drive its pin without port enable.
// - word_size_field holds word length minus one, 5-bit bit counter.
// - 4-bit frame counter steps on word wrap; frame up to 256 bits.
// - link modes ignore size fields; frame is 256 bit clocks.
// - two-bit mode field selects multi-channel, I2S, link16, link20.
// - master starts a new frame sync one bit clock before frame counter wraps.
// - master multi-channel sync is one bit clock high per frame.
// - master link sync is high 16 bit clocks, low 240.
// - master I2S sync has 50% duty; each edge marks a word.
// - slave multi-channel frame starts one bit after sync seen high.
// - slave I2S word starts one bit after either sync edge.
// - slave link frame starts one bit after sync seen high.
// - slave finishes the whole frame (in I2S the word), ignoring sync until its end.
// - data sampled on falling edge unless sample_edge_select is set.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module fcs_codec_port (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SERIAL_BIT_CLOCK_IN,
  output logic SERIAL_BIT_CLOCK_OUT,
  output logic SERIAL_BIT_CLOCK_OE,
  input wire logic FRAME_SYNC_PIN_IN,
  output logic FRAME_SYNC_PIN_OUT,
  output logic FRAME_SYNC_PIN_OE,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OUT_OE
);
  logic [31:0] port_control_one;
  logic [31:0] port_control_two;
  logic [15:0] buf_mem [8];
  logic [2:0] sy1, sy2, sy3, flt;
  logic [fcs_pkg::DIV_W-1:0] div_cnt;
  logic bclk_gen;
  logic [7:0] fbit;
  logic [4:0] bit_cnt;
  logic [3:0] word_cnt;
  logic [1:0] buf_idx;
  logic [15:0] shifter;
  logic fs_prev;
  fcs_pkg::fcs_state_e st, next_st;
  logic [7:0] next_fbit;
  logic [4:0] next_bit;
  logic [3:0] next_word;

  // control fields
  wire port_enable = port_control_one[fcs_pkg::C1_ENABLE];
  wire frame_sync_direction = port_control_one[fcs_pkg::C1_FS_DIR];
  wire idle_output_mode = port_control_one[fcs_pkg::C1_IDLE_MODE];
  wire [1:0] frame_sync_mode_field =
    port_control_one[fcs_pkg::C1_MODE_LSB +: 2];
  wire [fcs_pkg::DIV_W-1:0] bit_clock_divider =
    port_control_one[fcs_pkg::C1_DIV_LSB +: fcs_pkg::DIV_W];
  wire bit_clock_direction = port_control_two[fcs_pkg::C2_CLK_DIR];
  wire sample_edge_select = port_control_two[fcs_pkg::C2_EDGE];
  wire [3:0] word_size_field = port_control_two[fcs_pkg::C2_WS_LSB +: 4];
  wire [3:0] frame_length_counter =
    port_control_two[fcs_pkg::C2_FL_LSB +: 4];

  // pin synchronisers: a change counts once stages two and three agree
  wire [2:0] pin_raw = {SERIAL_DATA_IN, FRAME_SYNC_PIN_IN,
                        SERIAL_BIT_CLOCK_IN};
  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
          sy1[g] <= 1'b0;
          sy2[g] <= 1'b0;
          sy3[g] <= 1'b0;
          flt[g] <= 1'b0;
        end else begin
          sy1[g] <= pin_raw[g];
          sy2[g] <= sy1[g];
          sy3[g] <= sy2[g];
          if (sy2[g] == sy3[g]) flt[g] <= sy3[g];
        end
      end
    end
  endgenerate

  // bit clock generator: period is 2*(divider+1) reference clocks
  wire gen_on = !bit_clock_direction && (bit_clock_divider != '0);
  wire gen_tgl = gen_on && (div_cnt == bit_clock_divider);
  // the generator keeps running while the port is off, so a codec can be
  // clocked before the port is enabled
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !gen_on) begin
      div_cnt <= '0;
      bclk_gen <= 1'b0;
    end else if (gen_tgl) begin
      div_cnt <= '0;
      bclk_gen <= !bclk_gen;
    end else begin
      div_cnt <= div_cnt + {{(fcs_pkg::DIV_W - 1){1'b0}}, 1'b1};
    end
  end

  // bit clock events, from the generator or from the pin
  wire ext_chg = (sy2[fcs_pkg::SY_BCLK] == sy3[fcs_pkg::SY_BCLK]) &&
                 (sy3[fcs_pkg::SY_BCLK] != flt[fcs_pkg::SY_BCLK]);
  wire clk_rise = bit_clock_direction ?
                  (ext_chg && sy3[fcs_pkg::SY_BCLK]) : (gen_tgl && !bclk_gen);
  wire clk_fall = bit_clock_direction ?
                  (ext_chg && !sy3[fcs_pkg::SY_BCLK]) : (gen_tgl && bclk_gen);
  wire samp = port_enable && (sample_edge_select ? clk_rise : clk_fall);
  wire tick = port_enable && (sample_edge_select ? clk_fall : clk_rise);

  // frame geometry
  wire is_link = frame_sync_mode_field[1];
  wire is_i2s = frame_sync_mode_field == fcs_pkg::MODE_I2S;
  wire [8:0] flen = ({5'h0, word_size_field} + 9'h001) *
                    ({5'h0, frame_length_counter} + 9'h001);
  wire [7:0] flast = is_link ? fcs_pkg::AC_FRAME_LAST :
                     8'(flen - 9'h001);
  wire [4:0] wlast =
    (frame_sync_mode_field == fcs_pkg::MODE_AC20 && word_cnt != 4'h0) ?
    fcs_pkg::AC20_SLOT_LAST :
    (is_link ? fcs_pkg::AC_TAG_LAST : {1'b0, word_size_field});
  wire [4:0] dlast = (wlast > fcs_pkg::WORD_LAST_MAX) ?
                     fcs_pkg::WORD_LAST_MAX : wlast;
  wire at_fend = fbit == flast;
  wire at_wend = bit_cnt == wlast;

  // slave sync acceptance
  wire fs_cur = flt[fcs_pkg::SY_FS];
  wire fs_hit = is_i2s ? (fs_cur != fs_prev) : fs_cur;
  wire may_sync = (st == fcs_pkg::ST_IDLE) ||
                  (st == fcs_pkg::ST_RUN && (is_i2s ? at_wend : at_fend));
  wire take_sync = samp && frame_sync_direction && fs_hit && may_sync;
  wire running = port_enable &&
                 (!frame_sync_direction || st == fcs_pkg::ST_RUN);
  wire restart = frame_sync_direction ? (st == fcs_pkg::ST_ARMED) :
                 at_fend;
  wire will_run = frame_sync_direction ?
                  (st == fcs_pkg::ST_ARMED ||
                   (st == fcs_pkg::ST_RUN && !at_fend)) : port_enable;

  // a slave in idle lets the counters run on ticks; arming zeroes them,
  // so a stale count never reaches a frame
  always_comb begin
    next_fbit = fbit + 8'h01;
    next_bit = bit_cnt + 5'h01;
    next_word = word_cnt;
    if (restart) begin
      next_fbit = 8'h00;
      next_bit = 5'h00;
      next_word = 4'h0;
    end else if (at_wend) begin
      next_bit = 5'h00;
      next_word = word_cnt + 4'h1;
    end
  end

  always_comb begin
    next_st = st;
    if (take_sync) begin
      next_st = fcs_pkg::ST_ARMED;
    end else if (tick) begin
      if (st == fcs_pkg::ST_ARMED) next_st = fcs_pkg::ST_RUN;
      else if (st == fcs_pkg::ST_RUN && at_fend) next_st = fcs_pkg::ST_IDLE;
    end
  end

  // master frame sync shape, looked one bit ahead so the codec sees the
  // sync one bit clock before the first data bit
  wire [7:0] look = (next_fbit == flast) ? 8'h00 : next_fbit + 8'h01;
  wire fs_mc = next_fbit == flast;
  // high on the last bit of a frame and on bits 0 to 14: sixteen in all
  wire fs_link = (next_fbit == flast) ||
                 (next_fbit <= fcs_pkg::AC_SYNC_LAST);
  wire fs_i2s = look >= flen[8:1];
  wire next_fs = is_link ? fs_link : (is_i2s ? fs_i2s : fs_mc);

  // data path
  wire tx_load = will_run && next_bit == 5'h00;
  wire drive_next = will_run && next_bit <= fcs_pkg::WORD_LAST_MAX;
  wire [15:0] tx_word = buf_mem[{1'b1, buf_idx}];
  wire [15:0] shift_in = {shifter[14:0], flt[fcs_pkg::SY_SDI]};
  wire rx_bit = samp && running && bit_cnt <= dlast;
  wire rx_we = rx_bit && bit_cnt == dlast;
  wire [15:0] rx_word = shift_in << (4'hF - dlast[3:0]);

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !port_enable) begin
      fbit <= 8'h00;
      bit_cnt <= 5'h00;
      word_cnt <= 4'h0;
      buf_idx <= 2'h0;
      shifter <= 16'h0000;
      fs_prev <= 1'b0;
      st <= fcs_pkg::ST_IDLE;
    end else begin
      st <= next_st;
      if (samp) fs_prev <= fs_cur;
      if (tick) begin
        fbit <= next_fbit;
        bit_cnt <= next_bit;
        word_cnt <= next_word;
        if (tx_load) shifter <= tx_word;
      end
      if (rx_bit) shifter <= shift_in;
      if (rx_we) buf_idx <= buf_idx + 2'h1;
    end
  end

  // pin drivers
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !port_enable) begin
      FRAME_SYNC_PIN_OUT <= 1'b0;
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OUT_OE <= 1'b0;
    end else if (tick) begin
      if (!frame_sync_direction) FRAME_SYNC_PIN_OUT <= next_fs;
      SERIAL_DATA_OUT <= drive_next &&
                         (tx_load ? tx_word[15] : shifter[15]);
      SERIAL_DATA_OUT_OE <= drive_next || !idle_output_mode;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      SERIAL_BIT_CLOCK_OUT <= 1'b0;
      SERIAL_BIT_CLOCK_OE <= 1'b0;
      FRAME_SYNC_PIN_OE <= 1'b0;
    end else begin
      SERIAL_BIT_CLOCK_OUT <= bclk_gen;
      SERIAL_BIT_CLOCK_OE <= gen_on;
      FRAME_SYNC_PIN_OE <= port_enable && !frame_sync_direction;
    end
  end

  // APB slave: no wait states, answer registered in the setup cycle
  wire apb_setup = PSEL && !PENABLE;
  wire apb_wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  wire hit_c1 = PADDR == fcs_pkg::OFS_CTRL1;
  wire hit_c2 = PADDR == fcs_pkg::OFS_CTRL2;
  wire hit_st = PADDR == fcs_pkg::OFS_STATUS;
  wire hit_rx = PADDR[7:4] == fcs_pkg::WIN_RXBUF && PADDR[1:0] == 2'h0;
  wire hit_tx = PADDR[7:4] == fcs_pkg::WIN_TXBUF && PADDR[1:0] == 2'h0;
  wire addr_ok = hit_c1 || hit_c2 || hit_st || hit_rx || hit_tx;
  wire [31:0] status_word = {12'h000, word_cnt, fbit, 3'h0, running,
                             2'h0, buf_idx};
  wire [31:0] rd_val =
    hit_c1 ? port_control_one :
    hit_c2 ? port_control_two :
    hit_st ? status_word :
    hit_rx ? {16'h0000, buf_mem[{1'b0, PADDR[3:2]}]} :
    hit_tx ? {16'h0000, buf_mem[{1'b1, PADDR[3:2]}]} : 32'h0000_0000;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= apb_setup;
      PRDATA <= (apb_setup && !PWRITE && addr_ok) ? rd_val : 32'h0000_0000;
      PSLVERR <= apb_setup && !addr_ok;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      port_control_one <= fcs_pkg::C1_RESET;
      port_control_two <= fcs_pkg::C2_RESET;
    end else if (apb_wr) begin
      if (hit_c1) port_control_one <= PWDATA & fcs_pkg::C1_MASK;
      if (hit_c2) port_control_two <= PWDATA & fcs_pkg::C2_MASK;
    end
  end

  // receive half written by the engine, transmit half by software only
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < 8; i++) buf_mem[i] <= 16'h0000;
    end else begin
      if (rx_we && port_enable) buf_mem[{1'b0, buf_idx}] <= rx_word;
      if (apb_wr && hit_tx) buf_mem[{1'b1, PADDR[3:2]}] <= PWDATA[15:0];
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  AST_BCLK_DIR: assert property (
    bit_clock_direction |=> !SERIAL_BIT_CLOCK_OE)
    else $error("bit clock driven while set as input");
  AST_DIV_IGNORED: assert property (
    (bit_clock_direction && !ext_chg) |-> !(clk_rise || clk_fall))
    else $error("internal divider acted on external clock");
  AST_IDLE_LOW: assert property (
    (port_enable && !idle_output_mode && tick) |=> SERIAL_DATA_OUT_OE)
    else $error("idle data pin not driven low");
  AST_IDLE_VALUE: assert property (
    (tick && !drive_next) |=> !SERIAL_DATA_OUT)
    else $error("idle data bit not zero");
  AST_FS_DIR: assert property (
    ##1 FRAME_SYNC_PIN_OE == $past(port_enable && !frame_sync_direction))
    else $error("frame sync direction wrong");
  AST_RX_JUST: assert property (
    rx_we |-> ((rx_word << (dlast[3:0] + 4'h1)) == 16'h0000 ||
               dlast == 5'h0F))
    else $error("received low bits not zero");
  AST_IDX_STEP: assert property (
    (rx_we && port_enable) |=> buf_idx == $past(buf_idx) + 2'h1)
    else $error("buffer index did not step");
  AST_DISABLE_CLR: assert property (
    !port_enable |=> (fbit == 8'h00 && buf_idx == 2'h0 &&
                      st == fcs_pkg::ST_IDLE))
    else $error("disable did not reset counters");
  AST_MC_PULSE: assert property (
    (tick && !frame_sync_direction && port_enable &&
     frame_sync_mode_field == fcs_pkg::MODE_MC && flast != 8'h00 &&
     FRAME_SYNC_PIN_OUT) |=> !FRAME_SYNC_PIN_OUT)
    else $error("multi-channel sync longer than one bit");
  AST_SLAVE_HOLD: assert property (
    (st == fcs_pkg::ST_RUN && !may_sync) |=> st != fcs_pkg::ST_ARMED)
    else $error("sync accepted in mid frame");
  AST_LINK_SYNC: assert property (
    (tick && port_enable && !frame_sync_direction && is_link) |=>
    FRAME_SYNC_PIN_OUT == (fbit == 8'hFF || fbit < 8'h0F))
    else $error("link sync not high for sixteen bits");
  AST_SLAVE_START: assert property (
    (st == fcs_pkg::ST_ARMED && tick) |=>
    (st == fcs_pkg::ST_RUN && fbit == 8'h00 && bit_cnt == 5'h00))
    else $error("slave frame did not start after sync");
  AST_MASTER_WRAP: assert property (
    (tick && !frame_sync_direction && at_fend) |=>
    (fbit == 8'h00 && word_cnt == 4'h0))
    else $error("master frame counter did not wrap");
  AST_IDLE_HIZ: assert property (
    (tick && idle_output_mode && !drive_next) |=> !SERIAL_DATA_OUT_OE)
    else $error("idle data pin driven in release mode");
  AST_FS_SLAVE: assert property (
    frame_sync_direction |=> !FRAME_SYNC_PIN_OE)
    else $error("frame sync driven while slave");
  // bus side: every setup is answered one cycle later
  AST_APB_WAIT: assert property (
    (PSEL && !PENABLE) |=> PREADY)
    else $error("no answer after setup");
  AST_APB_ERR: assert property (
    PSLVERR |-> PREADY)
    else $error("error flag without ready");

  COV_MASTER_WRAP: cover property (
    tick && !frame_sync_direction && at_fend);
  COV_SLAVE_START: cover property (
    st == fcs_pkg::ST_ARMED ##[1:1000] st == fcs_pkg::ST_RUN);
  COV_RX_STORE: cover property (rx_we && buf_idx == 2'h3);
  COV_RISE_SAMPLE: cover property (
    rx_we && sample_edge_select && frame_sync_direction);
  COV_LINK_FRAME: cover property (
    tick && is_link && !frame_sync_direction && at_fend);
endmodule : fcs_codec_port
`default_nettype wire

/* File: fcs_codec_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fcs_codec_model #(
  parameter int HALF = 10
) (
  input wire logic ref_clk,
  output logic bclk,
  output logic fs,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic [15:0] got;
  int oe_hits;
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    sdi = 1'b0;
  end
  // bit clock runs only inside a frame; g places a stray sync mid-frame;
  // e parks the clock high, so data then moves on falling edges
  task run_frame(input int n, input int g, input logic [15:0] d,
                 input logic e);
    int i;
    got = 16'h0000;
    oe_hits = 0;
    bclk <= e;
    for (i = -1; i <= n; i++) begin
      repeat (HALF) @(posedge ref_clk);
      bclk <= !e;
      fs <= (i == -1) || (i == g);
      // outside the data bits the line shows no stale value
      sdi <= (i >= 0 && i < n) ? d[15 - i] : ~sdi;
      repeat (HALF) @(posedge ref_clk);
      bclk <= e;
      if (i >= 0 && i < n) begin
        got[15 - i] = sdo;
        oe_hits += int'(sdo_oe);
      end
    end
  endtask : run_frame
endmodule : fcs_codec_model
`default_nettype wire

/* File: framed_codec_serial_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module framed_codec_serial_port_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, bck_out, bck_oe, fs_out, fs_oe, sdo, sdo_oe;
  logic c_bclk, c_fs, sdi, bck_pin, fs_pin, err;
  logic [31:0] rd;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int hi, per, m;
  int ehi[4] = '{10, 40, 160, 160};
  int eper[4] = '{80, 80, 2560, 2560};
  logic [15:0] txv[4] = '{16'hA5FF, 16'h3C0F, 16'hC301, 16'h7EAA};
  assign bck_pin = bck_oe ? bck_out : c_bclk;
  assign fs_pin = fs_oe ? fs_out : c_fs;
  always #2.5 ref_clk = ~ref_clk;
  fcs_codec_port uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SERIAL_BIT_CLOCK_IN(bck_pin), .SERIAL_BIT_CLOCK_OUT(bck_out),
    .SERIAL_BIT_CLOCK_OE(bck_oe), .FRAME_SYNC_PIN_IN(fs_pin),
    .FRAME_SYNC_PIN_OUT(fs_out), .FRAME_SYNC_PIN_OE(fs_oe),
    .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo),
    .SERIAL_DATA_OUT_OE(sdo_oe));
  fcs_codec_model codec (.ref_clk(ref_clk), .bclk(c_bclk), .fs(c_fs),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string s);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, s);
  endtask : rdchk
  function automatic logic sig(input int s);
    return (s != 0) ? fs_out : bck_out;
  endfunction : sig
  task wait_lvl(input int s, input logic v);
    int n;
    n = 0;
    while (sig(s) !== v && n < 6000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_lvl
  // high time and full period, in system clocks, from one rising edge
  task meas(input int s);
    wait_lvl(s, 1'b0);
    wait_lvl(s, 1'b1);
    hi = 0;
    while (sig(s) === 1'b1 && hi < 6000) begin
      @(posedge ref_clk);
      hi++;
    end
    per = hi;
    while (sig(s) === 1'b0 && per < 6000) begin
      @(posedge ref_clk);
      per++;
    end
  endtask : meas
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdchk(fcs_pkg::OFS_CTRL1, fcs_pkg::C1_RESET, "ctrl1 reset");
    rdchk(fcs_pkg::OFS_CTRL2, fcs_pkg::C2_RESET, "ctrl2 reset");
    apb(1'b1, fcs_pkg::OFS_CTRL2, 32'hFFFF_FFFF);
    rdchk(fcs_pkg::OFS_CTRL2, fcs_pkg::C2_MASK, "ctrl2 mask");
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001, "unmapped error");
    apb(1'b1, 8'h10, 32'h0000_1234);
    rdchk(8'h10, 32'h0000_0000, "rx not writable");
    $display("test registers done");
    apb(1'b1, fcs_pkg::OFS_CTRL2, 32'h0000_0130);
    apb(1'b1, fcs_pkg::OFS_CTRL1, 32'h0004_0000);
    meas(0);
    chk(32'(hi), 32'h0000_0005, "bit clock high");
    chk(32'(per), 32'h0000_000A, "bit clock period");
    chk(32'(bck_oe), 32'h0000_0001, "bit clock driven");
    chk(32'(fs_oe), 32'h0000_0000, "sync pin off");
    $display("test generator done");
    for (m = 0; m < 4; m++) begin
      apb(1'b1, fcs_pkg::OFS_CTRL1, 32'h0004_0000);
      repeat (2) @(posedge ref_clk);
      chk(32'(fs_oe), 32'h0000_0000, "sync off when disabled");
      apb(1'b1, fcs_pkg::OFS_CTRL1, 32'h0004_0001 | (32'(m) << 4));
      repeat (2) @(posedge ref_clk);
      chk(32'(fs_oe), 32'h0000_0001, "sync driven as master");
      meas(1);
      meas(1);
      chk(32'(hi), 32'(ehi[m]), "sync high");
      chk(32'(per), 32'(eper[m]), "sync period");
    end
    $display("test master done");
    apb(1'b1, fcs_pkg::OFS_CTRL1, 32'h0000_0000);
    apb(1'b1, fcs_pkg::OFS_CTRL2, 32'h0000_0171);
    for (m = 0; m < 4; m++) begin
      apb(1'b1, 8'h20 + 8'(4 * m), {16'h0000, txv[m]});
    end
    apb(1'b1, fcs_pkg::OFS_CTRL1, 32'h0000_0007);
    repeat (2) @(posedge ref_clk);
    chk(32'(sdo_oe), 32'h0000_0000, "idle data released");
    chk(32'(fs_oe), 32'h0000_0000, "sync taken in");
    chk(32'(bck_oe), 32'h0000_0000, "bit clock taken in");
    codec.run_frame(16, -2, 16'h965A, 1'b0);
    chk({16'h0000, codec.got}, 32'h0000_A53C, "sent bits");
    chk(32'(codec.oe_hits), 32'h0000_0010, "data driven");
    rdchk(8'h10, 32'h0000_9600, "rx word 0");
    rdchk(8'h14, 32'h0000_5A00, "rx word 1");
    apb(1'b0, fcs_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0003, 32'h0000_0002, "index after frame");
    // a sync pulse in bit 5 must not restart the frame
    codec.run_frame(16, 5, 16'h3CC3, 1'b0);
    chk({16'h0000, codec.got}, 32'h0000_C37E, "sent bits 2");
    rdchk(8'h18, 32'h0000_3C00, "rx word 2");
    rdchk(8'h1C, 32'h0000_C300, "rx word 3");
    apb(1'b0, fcs_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0003, 32'h0000_0000, "index wraps");
    apb(1'b1, fcs_pkg::OFS_CTRL1, 32'h0000_0000);
    apb(1'b1, fcs_pkg::OFS_CTRL2, 32'h0000_0173);
    apb(1'b1, fcs_pkg::OFS_CTRL1, 32'h0000_0003);
    codec.run_frame(16, -2, 16'h1EE1, 1'b1);
    chk({30'h0, sdo_oe, sdo}, 32'h0000_0002, "idle driven low");
    chk({16'h0000, codec.got}, 32'h0000_A53C, "rising sent");
    rdchk(8'h10, 32'h0000_1E00, "rising rx word 0");
    rdchk(8'h14, 32'h0000_E100, "rising rx word 1");
    $display("test slave done");
    report_and_stop();
  end
endmodule : framed_codec_serial_port_tb
`default_nettype wire
